// file: core/cdm_input_decode.sv
// decode of the plus and minus input select codes
`include "cdm_regs.svh"

module cdm_input_decode
    import cdm_pkg::*;
(
    // select codes
    input wire cdm_sel_t plus_sel,
    input wire cdm_sel_t minus_sel,
    // decoded selections
    output logic [7:0] plus_onehot,
    output logic [7:0] minus_onehot,
    output logic same_input
);

    // ==========================================================
    // code n selects comparator_input_n
    function automatic cdm_onehot_t sel_decode(input cdm_sel_t code);
        sel_decode = 8'h01 << code;
    endfunction

    assign plus_onehot = sel_decode(plus_sel);
    assign minus_onehot = sel_decode(minus_sel);
    // both muxes on one pin would turn the comparator into a noise source
    assign same_input = (plus_sel == minus_sel);

endmodule

// file: core/cdm_pkg.sv
// types shared by the dac/mux control bank
package cdm_pkg;

    // ==========================================================
    // bus data phase tracking
    typedef enum logic [1:0]
    {
        PH_IDLE = 2'b00,
        PH_WRITE = 2'b01,
        PH_RWAIT = 2'b10,
        PH_RDONE = 2'b11
    } cdm_phase_t;

    // ==========================================================
    // field types
    typedef logic [2:0] cdm_sel_t;
    typedef logic [7:0] cdm_onehot_t;
    typedef logic [5:0] cdm_level_t;

endpackage

// file: core/cdm_regs.svh
// register offsets, field positions and reset values of the dac/mux bank
`ifndef CDM_REGS_SVH
`define CDM_REGS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define CDM_DAC_CTL_IDX 30'h0000_0004
`define CDM_MUX_CTL_IDX 30'h0000_0005

// ==========================================================
// reference dac control fields
`define CDM_DAC_EN_BIT 7
`define CDM_DAC_REFSEL_BIT 6
`define CDM_DAC_LVL_MSB 5
`define CDM_DAC_LVL_LSB 0
`define CDM_DAC_SHIFT 6
`define CDM_DAC_RESET 8'h00

// ==========================================================
// input select control fields
`define CDM_MUX_PT_BIT 7
`define CDM_MUX_RSVD_BIT 6
`define CDM_MUX_PLUS_MSB 5
`define CDM_MUX_PLUS_LSB 3
`define CDM_MUX_MINUS_MSB 2
`define CDM_MUX_MINUS_LSB 0
`define CDM_MUX_WMASK 8'hbf
`define CDM_MUX_RESET 8'h00

// ==========================================================
// ladder reference routing codes
`define CDM_REF1_ONEHOT 2'h1
`define CDM_REF2_ONEHOT 2'h2

`endif

// file: core/cdm_top.sv
// ahb-lite register bank steering the reference dac and input muxes
//
// Chosen here: the AHB-Lite interface to the registers.
`include "cdm_regs.svh"

// What this block does
// - select bit 0 ref one, 1 ref two
// - six-bit level code in dac bits 5-0
// - dac output is reference times (code+1)/64
// - mux bit 7 enables pass-through mode
// - mux bit 6 reads zero, ignores writes
// - plus select codes 0-7 pick inputs 0-7
// - minus select codes 0-7 pick inputs 0-7
// - equal selects force comparator shutdown
// - dac bit 7 powers ladder up or down
module cdm_top
    import cdm_pkg::*;
#(
    parameter logic [15:0] REF1_MV = 16'h0ce4,
    parameter logic [15:0] REF2_MV = 16'h0ce4
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // reference dac controls
    output logic ladder_enable,
    output logic supply_reference_select,
    output logic [1:0] ladder_ref_onehot,
    output logic [5:0] dac_level_code,
    output logic [15:0] dac_output_voltage,
    // input mux controls
    output logic passthrough_enable,
    output logic [7:0] plus_input_onehot,
    output logic [7:0] minus_input_onehot,
    output logic comparator_shutdown
);

    // ==========================================================
    // declarations
    cdm_phase_t phase_q;
    logic sel_dac_q;
    logic sel_mux_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic [7:0] dac_ctl_q;
    logic [7:0] dac_ctl_d;
    logic [7:0] mux_ctl_q;
    logic [7:0] mux_ctl_d;
    logic take;
    logic wr_dac;
    logic wr_mux;
    logic [7:0] plus_oh_d;
    logic [7:0] minus_oh_d;
    logic same_d;
    logic ladder_enable_q;
    logic refsel_q;
    logic [1:0] ref_oh_q;
    logic [5:0] level_q;
    logic [15:0] volts_q;
    logic pass_q;
    logic [7:0] plus_oh_q;
    logic [7:0] minus_oh_q;
    logic shutdown_q;

    // ==========================================================
    // helper functions
    function automatic logic reg_hit(input logic [31:0] addr,
                                     input logic [29:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[31:2] == idx);
    endfunction

    function automatic logic [15:0] dac_level_mv(input logic [15:0] vref,
                                                 input logic [5:0] code);
        logic [22:0] prod;
        prod = 23'(vref) * (23'(code) + 23'h000001);
        dac_level_mv = prod[21:6];
    endfunction

    // ==========================================================
    // bus address phase
    // hsize is ignored: only whole-word transfers are expected
    assign take = hsel && htrans[1] && hready;
    assign wr_dac = (phase_q == PH_WRITE) && sel_dac_q;
    assign wr_mux = (phase_q == PH_WRITE) && sel_mux_q;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            phase_q <= PH_IDLE;
            sel_dac_q <= 1'b0;
            sel_mux_q <= 1'b0;
        end
        else if (phase_q == PH_RWAIT)
        begin
            phase_q <= PH_RDONE;
        end
        else if (take)
        begin
            phase_q <= hwrite ? PH_WRITE : PH_RWAIT;
            sel_dac_q <= reg_hit(haddr, `CDM_DAC_CTL_IDX);
            sel_mux_q <= reg_hit(haddr, `CDM_MUX_CTL_IDX);
        end
        else
        begin
            phase_q <= PH_IDLE;
        end
    end

    // ==========================================================
    // bus data phase
    // reads take one wait state so a read right behind a write
    // always returns the freshly written value
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            hreadyout_q <= 1'b1;
        end
        else
        begin
            hreadyout_q <= (phase_q == PH_RWAIT) || !(take && !hwrite);
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            hrdata_q <= 32'h0000_0000;
        end
        else if (phase_q == PH_RWAIT)
        begin
            case ({sel_dac_q, sel_mux_q})
                2'b10: hrdata_q <= {24'h00_0000, dac_ctl_q};
                2'b01: hrdata_q <= {24'h00_0000, mux_ctl_q};
                default: hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // ==========================================================
    // control registers
    always_comb
    begin
        dac_ctl_d = dac_ctl_q;
        mux_ctl_d = mux_ctl_q;
        if (wr_dac)
        begin
            dac_ctl_d = hwdata[7:0];
        end
        if (wr_mux)
        begin
            // reserved bit is masked off and stays zero
            mux_ctl_d = hwdata[7:0] & `CDM_MUX_WMASK;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            dac_ctl_q <= `CDM_DAC_RESET;
            mux_ctl_q <= `CDM_MUX_RESET;
        end
        else
        begin
            dac_ctl_q <= dac_ctl_d;
            mux_ctl_q <= mux_ctl_d;
        end
    end

    // ==========================================================
    // input select decode
    cdm_input_decode u_decode
    (
        .plus_sel(mux_ctl_d[`CDM_MUX_PLUS_MSB:`CDM_MUX_PLUS_LSB]),
        .minus_sel(mux_ctl_d[`CDM_MUX_MINUS_MSB:`CDM_MUX_MINUS_LSB]),
        .plus_onehot(plus_oh_d),
        .minus_onehot(minus_oh_d),
        .same_input(same_d)
    );

    // ==========================================================
    // registered mux outputs
    // decoded from the next register value so the flops always
    // match the stored selects, with no extra cycle of lag
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pass_q <= 1'b0;
            plus_oh_q <= 8'h01;
            minus_oh_q <= 8'h01;
            shutdown_q <= 1'b1;
        end
        else
        begin
            pass_q <= mux_ctl_d[`CDM_MUX_PT_BIT];
            plus_oh_q <= plus_oh_d;
            minus_oh_q <= minus_oh_d;
            shutdown_q <= same_d;
        end
    end

    // ==========================================================
    // registered dac outputs
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ladder_enable_q <= 1'b0;
            refsel_q <= 1'b0;
            ref_oh_q <= `CDM_REF1_ONEHOT;
            level_q <= 6'h00;
            volts_q <= 16'h0000;
        end
        else
        begin
            ladder_enable_q <= dac_ctl_d[`CDM_DAC_EN_BIT];
            refsel_q <= dac_ctl_d[`CDM_DAC_REFSEL_BIT];
            ref_oh_q <= dac_ctl_d[`CDM_DAC_REFSEL_BIT] ?
                `CDM_REF2_ONEHOT : `CDM_REF1_ONEHOT;
            level_q <= dac_ctl_d[`CDM_DAC_LVL_MSB:`CDM_DAC_LVL_LSB];
            // powered-down ladder drives nothing
            if (!dac_ctl_d[`CDM_DAC_EN_BIT])
            begin
                volts_q <= 16'h0000;
            end
            else
            begin
                volts_q <= dac_level_mv(
                    dac_ctl_d[`CDM_DAC_REFSEL_BIT] ? REF2_MV : REF1_MV,
                    dac_ctl_d[`CDM_DAC_LVL_MSB:`CDM_DAC_LVL_LSB]);
            end
        end
    end

    assign ladder_enable = ladder_enable_q;
    assign supply_reference_select = refsel_q;
    assign ladder_ref_onehot = ref_oh_q;
    assign dac_level_code = level_q;
    assign dac_output_voltage = volts_q;
    assign passthrough_enable = pass_q;
    assign plus_input_onehot = plus_oh_q;
    assign minus_input_onehot = minus_oh_q;
    assign comparator_shutdown = shutdown_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_ref_route_sel: assert property (
        wr_dac |=> (supply_reference_select == $past(hwdata[6])) &&
            (ladder_ref_onehot == ($past(hwdata[6]) ? 2'h2 : 2'h1)))
        else $error("ladder reference not routed from select bit");

    a_level_code_write: assert property (
        wr_dac |=> dac_level_code == $past(hwdata[5:0]))
        else $error("dac level code does not follow write");

    a_dac_full_scale: assert property (
        (ladder_enable && dac_level_code == 6'h3f) |->
            dac_output_voltage ==
                (supply_reference_select ? REF2_MV : REF1_MV))
        else $error("top dac code is not full reference");

    a_dac_low_step: assert property (
        (ladder_enable && dac_level_code == 6'h00) |->
            dac_output_voltage ==
                ((supply_reference_select ? REF2_MV : REF1_MV) >> 6))
        else $error("lowest dac code is not one sixty-fourth");

    a_passthru_write: assert property (
        wr_mux |=> passthrough_enable == $past(hwdata[7]))
        else $error("pass-through bit does not follow write");

    a_rsvd_reads_zero: assert property (
        (phase_q == PH_RWAIT && sel_mux_q) |=> hrdata[6] == 1'b0)
        else $error("reserved mux bit read back as one");

    a_plus_decode: assert property (
        wr_mux |=> plus_input_onehot == (8'h01 << $past(hwdata[5:3])))
        else $error("plus input decode wrong");

    a_minus_decode: assert property (
        wr_mux |=> minus_input_onehot == (8'h01 << $past(hwdata[2:0])))
        else $error("minus input decode wrong");

    a_same_shutdown: assert property (
        comparator_shutdown == (plus_input_onehot == minus_input_onehot))
        else $error("shutdown does not match equal selects");

    a_ladder_power: assert property (
        wr_dac |=> (ladder_enable == $past(hwdata[7])) &&
            (ladder_enable || dac_output_voltage == 16'h0000))
        else $error("ladder power state wrong");

    a_shutdown_timing: assert property (
        (wr_mux && hwdata[5:3] == hwdata[2:0]) |=> comparator_shutdown)
        else $error("shutdown late after equal-select write");

    a_read_wait: assert property (
        (take && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state missing");

    c_shutdown_write: cover property (
        wr_mux ##1 comparator_shutdown);
    c_mux_read: cover property (
        (phase_q == PH_RWAIT && sel_mux_q) ##1 hreadyout);
    c_dac_full: cover property (
        ladder_enable && dac_level_code == 6'h3f && supply_reference_select);

endmodule

// file: tb/cdm_top_tb.sv
// self-checking bench for the dac/mux control bank over ahb-lite
`include "cdm_regs.svh"

module cdm_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // stimulus and observation
    localparam logic [15:0] R1 = 16'h0ce4;
    localparam logic [15:0] R2 = 16'h0800;
    localparam logic [31:0] DAC_A = {`CDM_DAC_CTL_IDX, 2'b00};
    localparam logic [31:0] MUX_A = {`CDM_MUX_CTL_IDX, 2'b00};
    localparam logic [31:0] BAD_A = 32'h0000_0018;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, ladder_enable, supply_reference_select;
    logic passthrough_enable, comparator_shutdown;
    logic [31:0] hrdata;
    logic [1:0] ladder_ref_onehot;
    logic [5:0] dac_level_code;
    logic [15:0] dac_output_voltage;
    logic [7:0] plus_input_onehot, minus_input_onehot;
    logic [7:0] dac_v, mux_v;
    int num_errors = 0;
    int comparisons = 0;

    always #20 clock = ~clock;

    // hready is the lone slave's own ready
    cdm_top #(.REF1_MV(R1), .REF2_MV(R2)) dut (
        .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ladder_enable(ladder_enable),
        .supply_reference_select(supply_reference_select),
        .ladder_ref_onehot(ladder_ref_onehot),
        .dac_level_code(dac_level_code),
        .dac_output_voltage(dac_output_voltage),
        .passthrough_enable(passthrough_enable),
        .plus_input_onehot(plus_input_onehot),
        .minus_input_onehot(minus_input_onehot),
        .comparator_shutdown(comparator_shutdown)
    );

    // ==========================================================
    // reporting
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    // ==========================================================
    // bus master: hold each phase until hready is seen high
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [7:0] wd, output logic [31:0] rd);
        // start just after a rising edge, never in the step of a release
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clock);
        while (hready_seen() !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge clock);
        while (hready_seen() !== 1'b1) @(posedge clock);
        rd = hrdata;
        hsel <= 1'b0;
    endtask

    function automatic logic hready_seen();
        return hreadyout;
    endfunction

    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask

    task automatic rd_reg(input logic [31:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        bus(1'b0, a, 8'h00, rd);
        check(rd, {24'h0, exp}, "read data");
    endtask

    // expected outputs follow straight from the two stored bytes
    task automatic chk_outs;
        logic [31:0] v;
        v = (32'(dac_v[6] ? R2 : R1) * (32'(dac_v[5:0]) + 32'h1)) >> 6;
        @(negedge clock);
        check(32'(hresp), 32'h0, "hresp");
        check(32'(ladder_enable), 32'(dac_v[7]), "enable");
        check(32'(supply_reference_select), 32'(dac_v[6]), "ref");
        check(32'(ladder_ref_onehot), dac_v[6] ? 32'h2 : 32'h1, "lad");
        check(32'(dac_level_code), 32'(dac_v[5:0]), "level");
        check(32'(dac_output_voltage), dac_v[7] ? v : 32'h0, "volt");
        check(32'(passthrough_enable), 32'(mux_v[7]), "pass");
        check(32'(plus_input_onehot), 32'h1 << mux_v[5:3], "plus");
        check(32'(minus_input_onehot), 32'h1 << mux_v[2:0], "minus");
        check(32'(comparator_shutdown), 32'(mux_v[5:3] == mux_v[2:0]),
              "shutdown");
    endtask

    // ==========================================================
    // tests
    initial
    begin
        repeat (5000) @(posedge clock);
        num_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        test_done();
    end

    initial
    begin
        logic [7:0] dac_tab [8];
        logic [2:0] ms;
        dac_tab = '{8'h00, 8'h3f, 8'hbf, 8'hff, 8'hc0, 8'h80, 8'h95, 8'hea};
        dac_v = 8'h00;
        mux_v = 8'h00;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        chk_outs();
        rd_reg(DAC_A, 8'h00);
        rd_reg(MUX_A, 8'h00);
        $display("test reset done");
        // every plus and minus code, four of them equal; bit 6 always set
        for (int i = 0; i < 8; i++)
        begin
            ms = i[0] ? 3'(i) : 3'(i) ^ 3'h4;
            wr_reg(MUX_A, {i[1], 1'b1, 3'(i), ms});
            mux_v = {i[1], 1'b0, 3'(i), ms};
            chk_outs();
            rd_reg(MUX_A, mux_v);
        end
        $display("test input select done");
        // both references, ladder on and off, codes 0 and 63
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(DAC_A, dac_tab[i]);
            dac_v = dac_tab[i];
            chk_outs();
            rd_reg(DAC_A, dac_v);
        end
        $display("test reference dac done");
        // an unmapped word must leave both registers alone
        wr_reg(BAD_A, 8'hff);
        rd_reg(BAD_A, 8'h00);
        rd_reg(DAC_A, dac_v);
        rd_reg(MUX_A, mux_v);
        chk_outs();
        $display("test unmapped done");
        test_done();
    end
endmodule
